// ---- hdl/citen_defs.vh ----
// Purpose: constants for the exception/interrupt/trap entry unit
// Assumes: 32-bit byte addresses, bit 31 is the msb
// Notes: vectors, status bit reset values and field positions
`ifndef CITEN_DEFS_VH
`define CITEN_DEFS_VH

// vector addresses
`define CITEN_VEC_RESET 32'h00000000
`define CITEN_VEC_BOOT 32'h80000000
`define CITEN_VEC_BREAK 32'h00000010
`define CITEN_VEC_TRAP_BASE 32'h00000040
`define CITEN_VEC_TRAP_LAST 32'h0000007c
`define CITEN_VEC_EXT 32'h00000080
`define CITEN_VEC_EXT_FLASH 32'h00804000

// trap return offset and trap vector stride
`define CITEN_TRAP_RET_OFS 32'h00000004
`define CITEN_TRAP_STRIDE_SH 2

// status bit reset values
`define CITEN_SM_RST 1'b0
`define CITEN_IE_RST 1'b0
`define CITEN_C_RST 1'b0

// position of the halfword flag in the saved pc (msb-first numbering bit 30 = lsb index 1)
`define CITEN_HALF_POS 1

`endif

// ---- hdl/citen_edge_sync.v ----
// Purpose: two-flop synchroniser with falling edge detector
// Assumes: async pin input, active-low
// Notes: first flop feeds only the second flop
`timescale 1ns/100ps
module citen_edge_sync (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin in, edge out
  input wire pin_n,
  output reg fall_q
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  // resets high so a pin idle high at reset gives no edge; a pin held low through reset gives one edge after release
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      meta_q <= pin_n;
      sync_q <= meta_q;
      prev_q <= sync_q;
      fall_q <= prev_q & ~sync_q;
    end
  end
endmodule // citen_edge_sync

// ---- hdl/citen_vec_sel.v ----
// Purpose: vector address selection for entry events
// Assumes: one-hot selects from the sequencer
// Notes: purely combinational
`timescale 1ns/100ps
`include "citen_defs.vh"
module citen_vec_sel (
  // event selects
  input wire sel_reset,
  input wire sel_trap,
  input wire sel_break,
  input wire sel_ext,
  // mode straps and trap number
  input wire boot_mode,
  input wire flash_ew_mode,
  input wire [3:0] trap_num,
  // result
  output reg [31:0] vec_addr
);
  // trap vectors, one word per number, ascending
  wire [31:0] trap_vec;
  assign trap_vec = `CITEN_VEC_TRAP_BASE + ({28'h0000000, trap_num} << `CITEN_TRAP_STRIDE_SH);

  // priority mirrors the sequencer's priority
  always @* begin
    vec_addr = `CITEN_VEC_RESET;
    if (sel_reset) begin
      vec_addr = boot_mode ? `CITEN_VEC_BOOT : `CITEN_VEC_RESET;
    end else if (sel_trap) begin
      vec_addr = trap_vec;
    end else if (sel_break) begin
      vec_addr = `CITEN_VEC_BREAK;
    end else if (sel_ext) begin
      vec_addr = flash_ew_mode ? `CITEN_VEC_EXT_FLASH : `CITEN_VEC_EXT;
    end
  end
endmodule // citen_vec_sel

// ---- hdl/citen_entry.v ----
// Purpose: hardware entry/exit sequencing for reset, break, external irq and trap
// Assumes: pipeline signals are on clk; break pin and irq request may be async
// Notes: one event is taken per clock; redirect is a one-cycle pulse
// Summary of operation
// - reset accepted any cycle, highest priority
// - reset initialises status bits, saved bits undefined
// - reset vector zero, boot rom in boot
// - break raised on falling edge of pin
// - break ignores the irq enable bit
// - no accept after word-aligned 16-bit non-branch
// - entry copies status bits to saved bits
// - break/irq save word-aligned pc to backup
// - break vectors to address 0x10
// - irq sampled at word breaks when enabled
// - irq vector 0x80, ram in flash mode
// - trap operand 0-15 selects own vector
// - trap saves trap pc plus four
// - saved pc halfword bit shows trap alignment
// - return clears two low pc bits
// - trap vectors 0x40 to 0x7c ascending
// - redirect last; return runs exit processing
// - priority reset, trap, break, external irq
`timescale 1ns/100ps
`include "citen_defs.vh"
module citen_entry (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins and interrupt controller
  input wire break_pin_n,
  input wire ext_irq_req,
  // mode straps (pins)
  input wire boot_mode_pin,
  input wire flash_ew_pin,
  // pipeline instruction break
  input wire insn_break,
  input wire [31:0] cur_pc,
  input wire prev_half_aligned,
  input wire prev_was_branch,
  // pipeline trap and return
  input wire trap_exec,
  input wire [3:0] trap_num,
  input wire [31:0] trap_pc,
  input wire rte_exec,
  // status word and backup pc writes from software
  input wire psw_wr,
  input wire [2:0] psw_wdata,
  input wire bpc_wr,
  input wire [31:0] bpc_wdata,
  // redirect to pipeline
  output reg redirect_q,
  output reg [31:0] redirect_addr_q,
  // state shown to pipeline
  output reg stack_mode_bit_q,
  output reg irq_enable_bit_q,
  output reg carry_bit_q,
  output reg saved_stack_mode_bit_q,
  output reg saved_irq_enable_bit_q,
  output reg saved_carry_bit_q,
  output reg [31:0] backup_program_counter_q,
  output reg [3:0] event_q
);
  // ---------------------------------------------------------------
  // states of the entry sequencer
  // ---------------------------------------------------------------
  localparam ST_RESET = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg break_pend_q;
  reg break_pend_d;
  reg irq_meta_q;
  reg irq_sync_q;
  reg boot_meta_q;
  reg boot_q;
  reg flash_meta_q;
  reg flash_q;
  wire break_fall;
  wire [31:0] vec_addr;
  wire ok_window;
  wire take_trap;
  wire take_break;
  wire take_ext;
  wire take_rte;
  wire [31:0] trap_ret;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // break edge detect
  citen_edge_sync u_brk (
    .clk(clk),
    .rst(rst),
    .pin_n(break_pin_n),
    .fall_q(break_fall)
  );

  // level inputs from outside pass two flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= ext_irq_req;
      irq_sync_q <= irq_meta_q;
    end
  end

  // straps keep sampling through reset so the boot vector is known at release
  always @(posedge clk) begin
    boot_meta_q <= boot_mode_pin;
    boot_q <= boot_meta_q;
    flash_meta_q <= flash_ew_pin;
    flash_q <= flash_meta_q;
  end

  // ---------------------------------------------------------------
  // acceptance
  // ---------------------------------------------------------------
  // blocked after aligned 16-bit
  assign ok_window = insn_break & ~cur_pc[1] & (~prev_half_aligned | prev_was_branch);
  assign take_trap = (state_q == ST_RUN) & trap_exec;
  assign take_break = (state_q == ST_RUN) & ~trap_exec & break_pend_q & ok_window;
  // irq needs enable and word break
  assign take_ext = (state_q == ST_RUN) & ~trap_exec & ~take_break & irq_sync_q &
                    irq_enable_bit_q & ok_window;
  assign take_rte = (state_q == ST_RUN) & rte_exec & ~trap_exec;
  assign trap_ret = trap_pc + `CITEN_TRAP_RET_OFS;

  // break edge held until taken; a new edge wins over the take
  always @* begin
    break_pend_d = break_pend_q;
    if (take_break) begin
      break_pend_d = 1'b0;
    end
    if (break_fall) begin
      break_pend_d = 1'b1;
    end
  end

  citen_vec_sel u_vec (
    .sel_reset(state_q == ST_RESET),
    .sel_trap(take_trap),
    .sel_break(take_break),
    .sel_ext(take_ext),
    .boot_mode(boot_q),
    .flash_ew_mode(flash_q),
    .trap_num(trap_num),
    .vec_addr(vec_addr)
  );

  // sequencer: one reset cycle issues the reset vector, then run
  always @* begin
    case (state_q)
      ST_RESET: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_RESET;
    endcase
  end

  // ---------------------------------------------------------------
  // state, status and backup registers
  // ---------------------------------------------------------------
  // async reset any cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
      break_pend_q <= 1'b0;
      redirect_q <= 1'b0;
      redirect_addr_q <= 32'h00000000;
      event_q <= 4'h0;
      stack_mode_bit_q <= `CITEN_SM_RST;
      irq_enable_bit_q <= `CITEN_IE_RST;
      carry_bit_q <= `CITEN_C_RST;
      // saved copies are undefined by design; zero keeps sim clean
      saved_stack_mode_bit_q <= 1'b0;
      saved_irq_enable_bit_q <= 1'b0;
      saved_carry_bit_q <= 1'b0;
      backup_program_counter_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      break_pend_q <= break_pend_d;
      redirect_q <= 1'b0;
      event_q <= 4'h0;
      if (state_q == ST_RESET) begin
        redirect_q <= 1'b1;
        redirect_addr_q <= vec_addr;
        event_q <= 4'h1;
      end else if (take_trap | take_break | take_ext) begin
        saved_stack_mode_bit_q <= stack_mode_bit_q;
        saved_irq_enable_bit_q <= irq_enable_bit_q;
        saved_carry_bit_q <= carry_bit_q;
        irq_enable_bit_q <= 1'b0;
        carry_bit_q <= 1'b0;
        if (take_trap) begin
          // trap pc plus four keeps alignment bit
          backup_program_counter_q <= trap_ret;
          event_q <= 4'h2;
        end else begin
          backup_program_counter_q <= {cur_pc[31:2], 2'b00};
          event_q <= take_break ? 4'h4 : 4'h8;
        end
        redirect_q <= 1'b1;
        redirect_addr_q <= vec_addr;
      end else if (take_rte) begin
        stack_mode_bit_q <= saved_stack_mode_bit_q;
        irq_enable_bit_q <= saved_irq_enable_bit_q;
        carry_bit_q <= saved_carry_bit_q;
        redirect_q <= 1'b1;
        redirect_addr_q <= {backup_program_counter_q[31:2], 2'b00};
      end else begin
        // software writes lose to any entry or exit in the same cycle
        if (psw_wr) begin
          stack_mode_bit_q <= psw_wdata[2];
          irq_enable_bit_q <= psw_wdata[1];
          carry_bit_q <= psw_wdata[0];
        end
        if (bpc_wr) begin
          backup_program_counter_q <= bpc_wdata;
        end
      end
    end
  end
endmodule // citen_entry

// ---- tb/citen_icu_model.sv ----
// Purpose: interrupt controller and break pin stand-in
// Assumes: seven level requests merge into one request line
// Notes: pin idles high, pulled low for a few clocks per fire
`timescale 1ns/100ps
module citen_icu_model (
  // clock
  input wire clk,
  // stimulus from the bench
  input wire [6:0] src_req,
  input wire fire,
  // towards the core
  output wire ext_irq_req,
  output reg break_pin_n = 1'b1
);
  reg [2:0] low_q = 3'h0;
  assign ext_irq_req = |src_req;
  // held low long enough that the two-flop sampler cannot miss the fall
  always @(posedge clk) begin
    if (fire)
      low_q <= 3'h6;
    else if (low_q != 3'h0)
      low_q <= low_q - 3'h1;
    break_pin_n <= (low_q == 3'h0) && !fire;
  end
endmodule // citen_icu_model

// ---- tb/citen_entry_checker.sv ----
// Purpose: port-level checks of the entry unit
// Assumes: one clock, async high reset
// Notes: bound onto every entry unit instance
`timescale 1ns/100ps
module citen_entry_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // pipeline side
  input wire insn_break,
  input wire trap_exec,
  input wire [3:0] trap_num,
  input wire [31:0] trap_pc,
  input wire rte_exec,
  // watched outputs
  input wire redirect_q,
  input wire [31:0] redirect_addr_q,
  input wire stack_mode_bit_q,
  input wire irq_enable_bit_q,
  input wire carry_bit_q,
  input wire saved_irq_enable_bit_q,
  input wire [31:0] backup_program_counter_q,
  input wire [3:0] event_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // --------
  // checks
  // --------
  trap_vector_a: assert property (trap_exec |=> redirect_q &&
    redirect_addr_q == 32'h40 + {$past(trap_num), 2'b00}) else $error("bad trap vector");
  trap_return_a: assert property (trap_exec |=>
    backup_program_counter_q == $past(trap_pc) + 32'h4) else $error("bad trap return");
  entry_clear_a: assert property (|event_q[3:1] |->
    !irq_enable_bit_q && !carry_bit_q) else $error("enable or carry left set");
  entry_save_a: assert property (|event_q[3:1] |->
    saved_irq_enable_bit_q == $past(irq_enable_bit_q)) else $error("enable not saved");
  stack_keep_a: assert property (|event_q[3:1] |->
    $stable(stack_mode_bit_q)) else $error("stack mode changed");
  rte_align_a: assert property (rte_exec && !trap_exec && !insn_break |=>
    redirect_q && redirect_addr_q[1:0] == 2'b00) else $error("return not aligned");
  rte_restore_a: assert property (rte_exec && !trap_exec && !insn_break |=>
    irq_enable_bit_q == $past(saved_irq_enable_bit_q)) else $error("enable not restored");
  break_vector_a: assert property (event_q == 4'h4 |->
    redirect_q && redirect_addr_q == 32'h10) else $error("bad break vector");
  ext_enable_a: assert property (event_q == 4'h8 |->
    $past(irq_enable_bit_q)) else $error("irq taken while disabled");
  cover property (event_q == 4'h2);
  cover property (event_q == 4'h4);
  cover property (event_q == 4'h8);
endmodule // citen_entry_checker
bind citen_entry citen_entry_checker chk_u (.*);

// ---- tb/citen_entry_tb.sv ----
// Purpose: self-checking bench for the entry unit
// Assumes: inputs change 1 ns after the rising clock
// Notes: break pin and irq request come from the controller model
`timescale 1ns/100ps
`include "citen_defs.vh"
module citen_entry_tb;
  reg clk, rst, boot, flash, ib, half, br, trap, return_from_exception_instruction, pw, fire;
  reg [3:0] tn;
  reg [6:0] src;
  reg [31:0] pc, tpc;
  reg [2:0] pd;
  wire brk_n, irq, rd;
  wire [5:0] st;
  wire [31:0] ra, bup;
  wire [3:0] ev;
  integer n_fail, n_compared, n, k;
  citen_icu_model icu_u (.clk(clk), .src_req(src), .fire(fire), .ext_irq_req(irq),
    .break_pin_n(brk_n));
  citen_entry dut_u (.clk(clk), .rst(rst), .break_pin_n(brk_n), .ext_irq_req(irq),
    .boot_mode_pin(boot), .flash_ew_pin(flash), .insn_break(ib), .cur_pc(pc),
    .prev_half_aligned(half), .prev_was_branch(br), .trap_exec(trap), .trap_num(tn),
    .trap_pc(tpc), .rte_exec(return_from_exception_instruction), .psw_wr(pw), .psw_wdata(pd), .bpc_wr(1'b0),
    .bpc_wdata(32'h0), .redirect_q(rd), .redirect_addr_q(ra), .stack_mode_bit_q(st[5]),
    .irq_enable_bit_q(st[4]), .carry_bit_q(st[3]), .saved_stack_mode_bit_q(st[2]),
    .saved_irq_enable_bit_q(st[1]), .saved_carry_bit_q(st[0]),
    .backup_program_counter_q(bup), .event_q(ev));
  // --------
  // helpers
  // --------
  task tick; begin @(posedge clk); #1; end endtask
  task chk(input [31:0] got, input [31:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task report_and_stop; begin
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  // bounded wait for a redirect pulse
  task wait_rd; begin
    k = 0;
    while (rd !== 1'b1 && k < 40) begin tick; k = k + 1; end
    if (k == 40) begin n_fail = n_fail + 1; report_and_stop; end
  end endtask
  task do_reset(input [31:0] v); begin
    rst = 1; repeat (10) tick; rst = 0; tick;
    chk({rd, ev}, 5'h11);
    chk(ra, v);
    chk(st[5:3], 3'h0);
  end endtask
  initial begin clk = 0; forever #4 clk = ~clk; end
  // --------
  // sequence
  // --------
  initial begin
    n_fail = 0; n_compared = 0; rst = 1; boot = 1; flash = 0; ib = 0; half = 0;
    br = 0; trap = 0; return_from_exception_instruction = 0; pw = 0; fire = 0; tn = 0; src = 0; pc = 32'h200;
    tpc = 0; pd = 0;
    do_reset(`CITEN_VEC_BOOT);
    boot = 0;
    do_reset(`CITEN_VEC_RESET);
    for (n = 0; n < 16; n = n + 1) begin
      pw = 1; pd = 3'h7; tick; pw = 0;
      trap = 1; tn = n[3:0]; tpc = 32'h100 + 2 * n; tick; trap = 0;
      chk({rd, ev}, 5'h12);
      chk(ra, 32'h40 + 4 * n);
      chk(bup, tpc + 32'h4);
      chk(st, 6'h27);
      return_from_exception_instruction = 1; tick; return_from_exception_instruction = 0;
      chk(ra, (tpc + 32'h4) & 32'hfffffffc);
      chk(st[5:3], 3'h7);
    end
    // break with irq disabled, first blocked after an aligned halfword
    pw = 1; pd = 3'h4; tick; pw = 0;
    ib = 1; half = 1; fire = 1; tick; fire = 0; repeat (8) tick;
    chk(bup, 32'h122);
    br = 1; wait_rd;
    chk(ev, 4'h4);
    chk(ra, `CITEN_VEC_BREAK);
    chk(bup, pc);
    br = 0; half = 0; src = 7'h10; repeat (8) tick;
    chk(rd, 1'b0);
    pw = 1; pd = 3'h2; tick; pw = 0; wait_rd;
    chk(ev, 4'h8);
    chk(ra, `CITEN_VEC_EXT);
    // trap beats a pending irq, then irq relocates in flash mode
    ib = 0; flash = 1; return_from_exception_instruction = 1; tick; return_from_exception_instruction = 0;
    trap = 1; tn = 4'h0; ib = 1; tick; trap = 0;
    chk(ev, 4'h2);
    ib = 0; return_from_exception_instruction = 1; tick; return_from_exception_instruction = 0; ib = 1; tick; wait_rd;
    chk(ra, `CITEN_VEC_EXT_FLASH);
    report_and_stop;
  end
endmodule // citen_entry_tb
